/* File: hw/cfr_readout.sv */
`timescale 1ns/1ps
// Behaviour
// - pulse reset gate after each sample
// - vertical clocks low while integrating
// - load line: cycle vertical, horizontal one high
// - horizontal phases toggle complementary per pixel
// - reset gate runs every pixel, halting only in a stall
// - horizontal clock at most 10 MHz
module cfr_readout
   import cfr_pkg::*;
#(
   parameter int N_LINES = LINES,
   parameter int N_STAGES = HREG_STAGES,
   parameter int PIX_CYCLES = PIX_CYC,
   parameter int V_CYCLES = TV_CYC,
   parameter int HS_CYCLES = THS_CYC
) (
   input wire logic ref_clk_i,            // 100 MHz clock
   input wire logic rst_b_i,              // async reset, active low
   input wire logic start_i,              // start a frame readout (pulse)
   output logic busy_o,                   // readout in progress
   output logic frame_done_o,             // frame finished (pulse)
   output logic vertical_phase_one_o,     // vertical clock phase 1
   output logic vertical_phase_two_o,     // vertical clock phase 2
   output logic horizontal_phase_one_o,   // horizontal clock phase 1
   output logic horizontal_phase_two_o,   // horizontal clock phase 2
   output logic reset_gate_o,             // floating diffusion reset gate
   output logic sample_o,                 // strobe to analog sampler
   input wire logic [PIX_W-1:0] adc_data_i, // converted sample, async source
   output logic pix_valid_o,              // pixel word available
   input wire logic pix_ready_i,          // receiver accepts pixel
   output logic [PIX_W-1:0] pix_data_o,   // pixel value
   output logic [1:0] pix_tag_o,          // dummy, dark or image
   output logic [9:0] pix_col_o,          // horizontal stage index
   output logic [9:0] pix_line_o          // line index
);
   localparam int HALF = PIX_CYCLES / 2;
   localparam int TW = PIX_W + 2 + 10 + 10;
   if (PIX_CYCLES < PIX_CYC_MIN || PIX_CYCLES < 4 || N_STAGES > 1023 || N_LINES > 1023 ||
       TR_CYC >= HALF || V_CYCLES < 1 || HS_CYCLES < 1) begin : g_bad_params
      $error("cfr_readout: parameters out of range");
   end

   cfr_state_type st_r, st_nxt;
   logic [15:0] tmr_r, tmr_nxt;
   logic [15:0] rgc_r, rgc_nxt;
   logic [1:0] vstep_r, vstep_nxt;
   logic [9:0] col_r, col_nxt, line_r, line_nxt;
   logic v1_r, v1_nxt, v2_r, v2_nxt, h1_r, h1_nxt, h2_r, h2_nxt;
   logic rg_r, rg_nxt, smp_r, smp_nxt, done_r, done_nxt;
   logic [PIX_W-1:0] adc_s1_r, adc_s2_r;
   logic in_ready, push;
   logic [1:0] tag;
   logic [TW-1:0] out_word;

   // sampler output crosses in from the analog side; not bit-coherent, the
   // conversion leads the strobe so the word is settled before it is read
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         adc_s1_r <= '0;
         adc_s2_r <= '0;
      end else begin
         adc_s1_r <= adc_data_i;
         adc_s2_r <= adc_s1_r;
      end
   end

   always_comb begin
      if (col_r < 10'(LEAD_DUMMY) || col_r >= 10'(N_STAGES - TRAIL_DUMMY)) begin
         tag = PTAG_DUMMY;
      end else if (col_r < 10'(LEAD_DUMMY + LEAD_DARK) ||
                   col_r >= 10'(N_STAGES - TRAIL_DUMMY - TRAIL_DARK) ||
                   line_r < 10'(DARK_LINES_TOP) ||
                   line_r >= 10'(N_LINES - DARK_LINES_BOT)) begin
         tag = PTAG_DARK;
      end else begin
         tag = PTAG_IMAGE;
      end
   end

   // word offered in the pixel's last cycle, while its strobe is high; a stall holds
   // the phase clocks, so no charge is pushed while the buffer is full
   assign push = (st_r == ST_HORZ) && (tmr_r == 16'(PIX_CYCLES - 1));

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      vstep_nxt = vstep_r;
      col_nxt = col_r;
      line_nxt = line_r;
      v1_nxt = 1'b0;
      v2_nxt = 1'b0;
      h1_nxt = h1_r;
      h2_nxt = h2_r;
      // reset gate runs in every state but halts in a stall; inside a line it follows the pixel timer, so it
      // clears the node after the sample and before the next dump
      rg_nxt = (rgc_r < 16'(TR_CYC));
      rgc_nxt = (rgc_r == 16'(PIX_CYCLES - 1)) ? 16'h0000 : rgc_r + 16'h0001;
      smp_nxt = 1'b0;
      done_nxt = 1'b0;
      unique case (st_r)
         ST_IDLE: begin
            h1_nxt = 1'b1;
            h2_nxt = 1'b0;
            tmr_nxt = 16'h0000;
            if (start_i) begin
               st_nxt = ST_VERT;
               line_nxt = 10'h000;
               vstep_nxt = 2'h0;
            end
         end
         ST_VERT: begin
            h1_nxt = 1'b1;
            h2_nxt = 1'b0;
            // two widths: v1 high, then v2 high; setup follows with both low (v2 falls, line enters)
            v1_nxt = (vstep_r == 2'h0);
            v2_nxt = (vstep_r == 2'h1);
            if (tmr_r == 16'(V_CYCLES - 1)) begin
               tmr_nxt = 16'h0000;
               vstep_nxt = vstep_r + 2'h1;
               if (vstep_r == 2'h1) begin
                  st_nxt = ST_SETUP;
               end
            end else begin
               tmr_nxt = tmr_r + 16'h0001;
            end
         end
         ST_SETUP: begin
            // setup may stretch up to one pixel so the line starts on the
            // reset gate's rhythm and no pulse is doubled
            if (tmr_r != 16'(HS_CYCLES - 1)) begin
               tmr_nxt = tmr_r + 16'h0001;
            end else if (rgc_r == 16'(PIX_CYCLES - 1)) begin
               tmr_nxt = 16'h0000;
               col_nxt = 10'h000;
               st_nxt = ST_HORZ;
            end
         end
         ST_HORZ: begin
            // h1 low / h2 high first half, swap at mid: h2 falls each pixel
            if (tmr_r == 16'h0000) begin
               h1_nxt = 1'b0;
               h2_nxt = 1'b1;
            end
            if (tmr_r == 16'(HALF)) begin
               h1_nxt = 1'b1;
               h2_nxt = 1'b0;
            end
            if (tmr_r == 16'(PIX_CYCLES - 2)) begin
               smp_nxt = 1'b1;
            end
            if (tmr_r == 16'(PIX_CYCLES - 1)) begin
               if (in_ready) begin
                  tmr_nxt = 16'h0000;
                  if (col_r == 10'(N_STAGES - 1)) begin
                     if (line_r == 10'(N_LINES - 1)) begin
                        st_nxt = ST_IDLE;
                        done_nxt = 1'b1;
                     end else begin
                        line_nxt = line_r + 10'h001;
                        vstep_nxt = 2'h0;
                        st_nxt = ST_VERT;
                     end
                  end else begin
                     col_nxt = col_r + 10'h001;
                  end
               end
            end else begin
               tmr_nxt = tmr_r + 16'h0001;
            end
         end
      endcase
      if (st_r == ST_HORZ) begin
         rgc_nxt = tmr_nxt;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= ST_IDLE;
         tmr_r <= 16'h0000;
         rgc_r <= 16'h0000;
         vstep_r <= 2'h0;
         col_r <= 10'h000;
         line_r <= 10'h000;
         v1_r <= 1'b0;
         v2_r <= 1'b0;
         h1_r <= 1'b1;
         h2_r <= 1'b0;
         rg_r <= 1'b0;
         smp_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         rgc_r <= rgc_nxt;
         vstep_r <= vstep_nxt;
         col_r <= col_nxt;
         line_r <= line_nxt;
         v1_r <= v1_nxt;
         v2_r <= v2_nxt;
         h1_r <= h1_nxt;
         h2_r <= h2_nxt;
         rg_r <= rg_nxt;
         smp_r <= smp_nxt;
         done_r <= done_nxt;
      end
   end

   cfr_skid #(.W(TW)) u_buf (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(push),
      .in_ready_o(in_ready),
      .in_data_i({adc_s2_r, tag, col_r, line_r}),
      .out_valid_o(pix_valid_o),
      .out_ready_i(pix_ready_i),
      .out_data_o(out_word)
   );

   assign pix_data_o = out_word[TW-1 -: PIX_W];
   assign pix_tag_o = out_word[21:20];
   assign pix_col_o = out_word[19:10];
   assign pix_line_o = out_word[9:0];
   assign busy_o = (st_r != ST_IDLE);
   assign frame_done_o = done_r;
   assign vertical_phase_one_o = v1_r;
   assign vertical_phase_two_o = v2_r;
   assign horizontal_phase_one_o = h1_r;
   assign horizontal_phase_two_o = h2_r;
   assign reset_gate_o = rg_r;
   assign sample_o = smp_r;
endmodule : cfr_readout

/* File: hw/cfr_pkg.sv */
package cfr_pkg;
   localparam int COLUMNS = 784;
   localparam int LINES = 520;
   localparam int HREG_STAGES = 796;
   localparam int LEAD_DUMMY = 10;
   localparam int LEAD_DARK = 4;
   localparam int TRAIL_DARK = 12;
   localparam int TRAIL_DUMMY = 2;
   localparam int DARK_LINES_TOP = 4;
   localparam int DARK_LINES_BOT = 4;
   localparam int CLK_MHZ = 100;
   localparam int HCLK_MAX_MHZ = 10;
   localparam int HCLK_NOM_MHZ = 4;
   localparam int PIX_CYC = CLK_MHZ / HCLK_NOM_MHZ;
   localparam int PIX_CYC_MIN = (CLK_MHZ + HCLK_MAX_MHZ - 1) / HCLK_MAX_MHZ;
   localparam int TV_NS = 2000;
   localparam int TV_CYC = (TV_NS * CLK_MHZ + 999) / 1000;
   localparam int THS_NS = 1000;
   localparam int THS_CYC = (THS_NS * CLK_MHZ + 999) / 1000;
   localparam int TR_NS = 20;
   localparam int TR_CYC = (TR_NS * CLK_MHZ + 999) / 1000;
   localparam int PIX_W = 16;
   localparam logic [1:0] PTAG_DUMMY = 2'h0;
   localparam logic [1:0] PTAG_DARK = 2'h1;
   localparam logic [1:0] PTAG_IMAGE = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_VERT = 2'b01,
      ST_SETUP = 2'b11,
      ST_HORZ = 2'b10
   } cfr_state_type;
endpackage : cfr_pkg

/* File: hw/cfr_skid.sv */
`timescale 1ns/1ps
module cfr_skid #(
   parameter int W = 18
) (
   input wire logic ref_clk_i,   // clock
   input wire logic rst_b_i,     // async reset
   input wire logic in_valid_i,  // word offered
   output logic in_ready_o,      // room left
   input wire logic [W-1:0] in_data_i, // word in
   output logic out_valid_o,     // word held
   input wire logic out_ready_i, // receiver takes
   output logic [W-1:0] out_data_o // word out
);
   logic [W-1:0] mem_r [2];
   logic [W-1:0] mem_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic push, pop;

   assign in_ready_o = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o = mem_r[rd_r];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      mem_nxt = mem_r;
      if (push) begin
         mem_nxt[wr_r] = in_data_i;
      end
      wr_nxt = push ? ~wr_r : wr_r;
      rd_nxt = pop ? ~rd_r : rd_r;
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         cnt_r <= 2'h0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
      end else begin
         mem_r <= mem_nxt;
         cnt_r <= cnt_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
      end
   end
endmodule : cfr_skid

/* File: verif/cfr_readout_properties.sv */
`timescale 1ns/1ps
module cfr_readout_chk
   import cfr_pkg::*;
#(
   parameter int N_STAGES = HREG_STAGES,
   parameter int V_CYCLES = TV_CYC
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_b_i, // reset
   input wire logic start_i, // start
   input wire logic busy_o, // busy
   input wire logic frame_done_o, // done
   input wire logic vertical_phase_one_o, // v1
   input wire logic vertical_phase_two_o, // v2
   input wire logic horizontal_phase_one_o, // h1
   input wire logic horizontal_phase_two_o, // h2
   input wire logic reset_gate_o, // reset gate
   input wire logic sample_o // strobe
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   int vcnt_r, hcnt_r, gap_r;
   logic seen_r;
   // counters, since lines and pulses outrun a repetition
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vcnt_r <= 0;
         hcnt_r <= 0;
         gap_r <= 99;
         seen_r <= 1'b0;
      end else begin
         vcnt_r <= vertical_phase_one_o ? vcnt_r + 1 : 0;
         gap_r <= $rose(horizontal_phase_two_o) ? 1 : gap_r + 1;
         if ($fell(vertical_phase_two_o)) hcnt_r <= 0;
         else if ($fell(horizontal_phase_two_o)) hcnt_r <= hcnt_r + 1;
         if ($fell(vertical_phase_two_o)) seen_r <= 1'b1;
         else if (frame_done_o) seen_r <= 1'b0;
      end
   end
   sequence rg_pulse_s;
      reset_gate_o ##1 reset_gate_o ##1 !reset_gate_o;
   endsequence
   sequence sample_s;
      ##[10:12] sample_o ##1 !sample_o;
   endsequence
   vert_idle_low_a: assert property (!busy_o |-> !vertical_phase_one_o && !vertical_phase_two_o)
      else $error("vertical clock moved while idle");
   load_h_held_a: assert property (vertical_phase_one_o || vertical_phase_two_o |->
      horizontal_phase_one_o && !horizontal_phase_two_o)
      else $error("horizontal phase not held during load");
   h_compl_a: assert property (horizontal_phase_one_o != horizontal_phase_two_o)
      else $error("horizontal phases not complementary");
   v_order_a: assert property ($fell(vertical_phase_one_o) |->
      vertical_phase_two_o && vcnt_r == V_CYCLES)
      else $error("vertical pulse width or order wrong");
   start_load_a: assert property (!busy_o && start_i |=> ##1 vertical_phase_one_o)
      else $error("load did not follow start");
   rg_pulse_a: assert property ($rose(reset_gate_o) |-> rg_pulse_s)
      else $error("reset gate pulse width wrong");
   dump_sample_a: assert property ($fell(horizontal_phase_two_o) |-> sample_s)
      else $error("no sample after charge dump");
   h_rate_a: assert property ($rose(horizontal_phase_two_o) |-> gap_r >= PIX_CYC_MIN)
      else $error("horizontal clock too fast");
   line_empty_a: assert property (($rose(vertical_phase_one_o) && seen_r) || frame_done_o |->
      hcnt_r == N_STAGES)
      else $error("horizontal register not emptied");
endmodule : cfr_readout_chk

bind cfr_readout cfr_readout_chk #(.N_STAGES(N_STAGES), .V_CYCLES(V_CYCLES)) u_chk (.*);

/* File: verif/cfr_ccd_model.sv */
`timescale 1ns/1ps
module cfr_ccd_model #(
   parameter int N_LINES = 12
) (
   input wire logic ref_clk_i, // clock
   input wire logic rst_b_i, // reset
   input wire logic vertical_phase_two_i, // v2
   input wire logic horizontal_phase_one_i, // h1
   input wire logic horizontal_phase_two_i, // h2
   input wire logic reset_gate_i, // reset gate
   output logic [15:0] adc_data_o // sampled output level
);
   logic v2_q, h2_q;
   logic [9:0] line_r, col_r;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         v2_q <= 1'b0;
         h2_q <= 1'b0;
         line_r <= 10'(N_LINES - 1);
         col_r <= 10'h0;
         adc_data_o <= 16'hffff;
      end else begin
         v2_q <= vertical_phase_two_i;
         h2_q <= horizontal_phase_two_i;
         if (v2_q && !vertical_phase_two_i) begin
            line_r <= (line_r == 10'(N_LINES - 1)) ? 10'h0 : line_r + 10'h1;
            // the line is lost unless phase one holds the register open
            col_r <= horizontal_phase_one_i ? 10'h0 : 10'h3ff;
         end
         if (h2_q && !horizontal_phase_two_i) begin
            adc_data_o <= {line_r[5:0], col_r};
            col_r <= col_r + 10'h1;
         end else if (reset_gate_i) begin
            adc_data_o <= 16'hffff;
         end
      end
   end
endmodule : cfr_ccd_model

/* File: verif/cfr_readout_tb.sv */
`timescale 1ns/1ps
module cfr_readout_tb;
   import cfr_pkg::*;
   localparam int NL = 12;
   localparam int NS = 30;
   logic ref_clk_i = 0, rst_b_i = 0, start_i = 0, pix_ready_i = 1, stall = 0;
   logic v1, v2, h1, h2, rg, smp, busy, done, pvalid;
   logic [15:0] adc, pdata;
   logic [1:0] ptag;
   logic [9:0] pcol, pline, e_line, e_col;
   int n_errors = 0, n_tests = 0, n_words = 0, cyc = 0;
   cfr_readout #(.N_LINES(NL), .N_STAGES(NS), .V_CYCLES(3), .HS_CYCLES(2)) u_dut (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .busy_o(busy),
      .frame_done_o(done), .vertical_phase_one_o(v1), .vertical_phase_two_o(v2),
      .horizontal_phase_one_o(h1), .horizontal_phase_two_o(h2), .reset_gate_o(rg),
      .sample_o(smp), .adc_data_i(adc), .pix_valid_o(pvalid), .pix_ready_i(pix_ready_i),
      .pix_data_o(pdata), .pix_tag_o(ptag), .pix_col_o(pcol), .pix_line_o(pline));
   cfr_ccd_model #(.N_LINES(NL)) u_ccd (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .vertical_phase_two_i(v2), .horizontal_phase_one_i(h1),
      .horizontal_phase_two_i(h2), .reset_gate_i(rg), .adc_data_o(adc));
   initial begin
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [1:0] exp_tag(logic [9:0] l, logic [9:0] c);
      if (c < LEAD_DUMMY || c >= NS - TRAIL_DUMMY) return PTAG_DUMMY;
      if (c < LEAD_DUMMY + LEAD_DARK || c >= NS - TRAIL_DUMMY - TRAIL_DARK) return PTAG_DARK;
      if (l < DARK_LINES_TOP || l >= NL - DARK_LINES_BOT) return PTAG_DARK;
      return PTAG_IMAGE;
   endfunction : exp_tag
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // receiver stalls half of every 128 cycles, long enough to fill the buffer
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         report_and_stop();
      end
      #1;
      pix_ready_i = !(stall && (cyc % 128) < 64);
   end
   // words are judged mid-cycle, where the handshake values have settled
   always @(negedge ref_clk_i) begin
      if (pvalid === 1'b1 && pix_ready_i === 1'b1) begin
         chk("data", {e_line[5:0], e_col}, pdata);
         chk("tag", 16'(exp_tag(e_line, e_col)), 16'(ptag));
         chk("col", 16'(e_col), 16'(pcol));
         chk("line", 16'(e_line), 16'(pline));
         n_words++;
         if (e_col == NS - 1) begin
            e_col = 0;
            e_line++;
         end else e_col++;
      end
   end
   task automatic t_idle;
      int k;
      k = 0;
      #1;
      chk("idle pins", 16'h8, 16'({v1, v2, h1, h2, busy, pvalid}));
      repeat (PIX_CYC) begin
         @(posedge ref_clk_i) #1;
         if (rg === 1'b1) k++;
      end
      chk("idle reset gate", 16'(TR_CYC), 16'(k));
   endtask : t_idle
   task automatic t_frame(logic st);
      int w;
      stall = st;
      n_words = 0;
      e_line = 0;
      e_col = 0;
      @(posedge ref_clk_i) #1 start_i = 1;
      @(posedge ref_clk_i) #1 start_i = 0;
      repeat (500) @(posedge ref_clk_i);
      #1 start_i = 1;
      @(posedge ref_clk_i) #1 start_i = 0;
      w = 0;
      while (done !== 1'b1 && w < 40000) begin
         @(posedge ref_clk_i);
         #1;
         w++;
      end
      stall = 0;
      repeat (10) @(posedge ref_clk_i);
      #1;
      chk("words", 16'(NL * NS), 16'(n_words));
      chk("busy after frame", 16'h0, 16'(busy));
   endtask : t_frame
   initial begin
      repeat (2) @(posedge ref_clk_i);
      #1 rst_b_i = 1;
      t_idle();
      t_frame(1'b0);
      t_frame(1'b1);
      report_and_stop();
   end
endmodule : cfr_readout_tb
